/* File: common/pss_pkg.sv */
// Purpose: constants and types of the program sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: all addresses are data or program memory locations
// What this block does
// RULE1 - Program counter advances by one after each instruction fetch.
// RULE2 - Program memory is 4096 words of 15 bits, 12-bit addressed.
// RULE3 - Reset loads program counter with 000H.
// RULE4 - Enabled external request with stack not full vectors to 004H.
// RULE5 - Enabled timer 0 overflow with stack not full vectors to 008H.
// RULE6 - Enabled timer 1 overflow with stack not full vectors to 00CH.
// RULE7 - Taken skip discards prefetched word, dummy cycle, continues at PC+2.
// RULE8 - Every program counter reload costs one extra dummy cycle.
// RULE9 - Writing counter_low_byte replaces bits 7..0, keeps bits 11..8.
// RULE10 - Jump/call load twelve bits from code; returns from stack.
// RULE11 - Table address is page bits or 1111 above pointer; results split.
// RULE12 - table_address_low at 07H is read/write; table_read_high read-only.
// RULE13 - Every table read takes two instruction cycles.
// RULE14 - Sixteen-entry return stack, invisible to software, index too.
// RULE15 - Call or interrupt acknowledge pushes; returns pop into counter.
// RULE16 - Reset leaves the stack index at top, stack empty.
// RULE17 - Interrupt with stack full waits until a return pops.
// RULE18 - Call with stack full pushes anyway, oldest entry lost.
// RULE19 - Data addresses 20H..FFH are general storage, below are specials.
// RULE20 - Indirect ports 00H/02H, pointers 01H/03H, working 05H, COUNTER_LOW_BYTE 06H.
// RULE21 - Every data location supports read-modify-write and bit operations.
// RULE22 - Indirect port reaches the location its memory pointer names.
// RULE23 - Indirect read of an indirect port gives 00H; write does nothing.
// RULE24 - Instruction cycle is four clocks; fetch overlaps execution.
// RULE25 - Both memory pointers are 8 bits wide.
// RULE26 - Interrupts are taken only at instruction boundaries.
package pss_pkg;
  localparam int PSS_PC_W = 12;
  localparam int PSS_PM_W = 15;
  localparam int PSS_DM_W = 8;
  localparam int PSS_STACK_DEPTH = 16;
  localparam int PSS_RAM_WORDS = 224;
  localparam logic [11:0] PSS_VEC_RESET = 12'h000;
  localparam logic [11:0] PSS_VEC_EXT = 12'h004;
  localparam logic [11:0] PSS_VEC_T0 = 12'h008;
  localparam logic [11:0] PSS_VEC_T1 = 12'h00C;
  localparam logic [3:0] PSS_LAST_PAGE = 4'hF;
  localparam logic [7:0] PSS_A_IND0 = 8'h00;
  localparam logic [7:0] PSS_A_MP0 = 8'h01;
  localparam logic [7:0] PSS_A_IND1 = 8'h02;
  localparam logic [7:0] PSS_A_MP1 = 8'h03;
  localparam logic [7:0] PSS_A_WORK = 8'h05;
  localparam logic [7:0] PSS_A_PCL = 8'h06;
  localparam logic [7:0] PSS_A_TABLE_ADDRESS_LOW = 8'h07;
  localparam logic [7:0] PSS_A_TABLE_READ_HIGH = 8'h08;
  localparam logic [7:0] PSS_A_RAM = 8'h20;
  localparam logic [7:0] PSS_ZERO8 = 8'h00;
  localparam logic [1:0] PSS_PH_FETCH = 2'h0;
  localparam logic [1:0] PSS_PH_CAPT = 2'h1;
  localparam logic [1:0] PSS_PH_END = 2'h3;
  typedef enum logic [2:0] {
    PSS_OP_NONE = 3'h0, PSS_OP_JUMP = 3'h1, PSS_OP_CALL = 3'h2,
    PSS_OP_RET = 3'h3, PSS_OP_SERVICE_RETURN = 3'h4, PSS_OP_SKIP = 3'h5,
    PSS_OP_TBL_CUR = 3'h6, PSS_OP_TBL_LAST = 3'h7
  } pss_op_t;
  typedef enum logic [1:0] {
    PSS_ST_DUMMY = 2'h0, PSS_ST_RUN = 2'h1, PSS_ST_TABLE = 2'h3
  } pss_state_t;
endpackage

/* File: common/pss_stack_if.sv */
// Purpose: link between sequencer and return stack
// Assumes: push and pop are one-cycle pulses, never together
// Notes: none
`timescale 1ns/1ps
interface pss_stack_if;
  logic push;
  logic pop;
  logic [11:0] push_pc;
  logic [11:0] top_pc;
  logic full;
  modport seq (output push, pop, push_pc, input top_pc, full);
  modport stack (input push, pop, push_pc, output top_pc, full);
endinterface

/* File: hdl/pss_stack.sv */
// Purpose: hardware return stack of program counter values
// Assumes: DEPTH is a power of two so the index wraps
// Notes: no software path reaches entries or index
`timescale 1ns/1ps
module pss_stack
  import pss_pkg::*;
#(
  parameter int DEPTH = PSS_STACK_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  pss_stack_if.stack sif
);
  localparam int IW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [PSS_PC_W-1:0] mem_q [DEPTH];
  logic [IW-1:0] idx_q;
  logic [CW-1:0] cnt_q;

  assign sif.full = (cnt_q == FULL_CNT);
  assign sif.top_pc = mem_q[idx_q - 1'b1]; // RULE15

  // Entries carry no reset; only the index matters
  always_ff @(posedge clk) begin
    if (sif.push) begin
      mem_q[idx_q] <= sif.push_pc; // RULE14
    end
  end

  // Wrapping index overwrites the oldest entry when full
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_q <= '0; // RULE16
      cnt_q <= '0;
    end else if (sif.push) begin
      idx_q <= idx_q + 1'b1; // RULE18
      if (!sif.full) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else if (sif.pop && cnt_q != '0) begin
      idx_q <= idx_q - 1'b1;
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

/* File: hdl/pss_sequencer.sv */
// Purpose: program flow, table reads and data memory map
// Assumes: PM_DATA valid one clock after PM_RD; EXEC_* valid
//   in the last clock of an instruction cycle
// Notes: special registers not held here go to the SFR_* ports
`timescale 1ns/1ps
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int STACK_DEPTH = PSS_STACK_DEPTH
) (
  input logic REF_CLK,
  input logic RESET,
  output logic [11:0] PM_ADDR,
  output logic PM_RD,
  input logic [14:0] PM_DATA,
  output logic [14:0] INSTR,
  output logic INSTR_VALID,
  output logic [1:0] CYCLE_PHASE,
  output logic [11:0] PROGRAM_COUNTER,
  input logic [2:0] EXEC_OP,
  input logic [11:0] EXEC_TARGET,
  input logic IRQ_EXT_REQ,
  input logic IRQ_T0_REQ,
  input logic IRQ_T1_REQ,
  output logic [2:0] IRQ_ACK,
  input logic [7:0] DM_ADDR,
  input logic DM_WR,
  input logic [7:0] DM_WDATA,
  output logic [7:0] DM_RDATA,
  output logic [7:0] WORKING_REGISTER,
  output logic [7:0] SFR_ADDR,
  output logic SFR_WR,
  output logic [7:0] SFR_WDATA,
  input logic [7:0] SFR_RDATA
);
  pss_stack_if sif ();

  pss_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk(REF_CLK),
    .rst(RESET),
    .sif(sif)
  );

  // Indirect ports resolve through their pointer
  function automatic logic [7:0] dm_resolve(
    input logic [7:0] a,
    input logic [7:0] p0,
    input logic [7:0] p1
  );
    logic [7:0] r;
    r = a;
    if (a == PSS_A_IND0) begin
      r = p0;
    end else if (a == PSS_A_IND1) begin
      r = p1;
    end
    return r;
  endfunction

  function automatic logic is_ram(input logic [7:0] a);
    return a >= PSS_A_RAM;
  endfunction

  pss_state_t state_q;
  pss_state_t state_d;
  logic [1:0] phase_q;
  logic [11:0] pc_q;
  logic [11:0] fetch_addr_q;
  logic [14:0] prefetch_q;
  logic [14:0] instr_q;
  logic [11:0] tbl_addr_q;
  logic [7:0] tbl_dest_q;
  logic [7:0] table_read_high_q;
  logic [7:0] table_address_low_q;
  logic [7:0] mp0_q;
  logic [7:0] mp1_q;
  logic [7:0] work_q;
  logic [7:0] rdata_q;
  logic pcl_load_q;
  logic [7:0] pcl_val_q;
  logic [2:0] ack_q;
  logic [7:0] ram_q [PSS_RAM_WORDS];

  // Phase and operation decode
  wire end_cyc = (phase_q == PSS_PH_END);
  wire capt = (phase_q == PSS_PH_CAPT);
  wire executing = (state_q == PSS_ST_RUN);
  wire fetching = (state_q != PSS_ST_TABLE);
  wire [2:0] op = executing ? EXEC_OP : PSS_OP_NONE;
  wire op_jump = (op == PSS_OP_JUMP) || (op == PSS_OP_CALL);
  wire op_call = (op == PSS_OP_CALL);
  wire op_ret = (op == PSS_OP_RET) || (op == PSS_OP_SERVICE_RETURN);
  wire op_skip = (op == PSS_OP_SKIP);
  wire op_tcur = (op == PSS_OP_TBL_CUR);
  wire op_tlast = (op == PSS_OP_TBL_LAST);
  wire op_tbl = op_tcur || op_tlast;

  // Data memory write path: datapath or table result
  wire tbl_wr = (state_q == PSS_ST_TABLE) && capt;
  wire wr_en = DM_WR || tbl_wr;
  wire [7:0] wr_raw = tbl_wr ? tbl_dest_q : DM_ADDR;
  wire [7:0] wr_data = tbl_wr ? PM_DATA[7:0] : DM_WDATA; // RULE11
  wire [7:0] wr_addr = dm_resolve(wr_raw, mp0_q, mp1_q); // RULE22
  wire [7:0] rd_addr = dm_resolve(DM_ADDR, mp0_q, mp1_q); // RULE22
  wire [7:0] ram_wi = wr_addr - PSS_A_RAM;
  wire [7:0] ram_ri = rd_addr - PSS_A_RAM;

  // Special locations held here
  wire wr_mp0 = wr_en && (wr_addr == PSS_A_MP0); // RULE20
  wire wr_mp1 = wr_en && (wr_addr == PSS_A_MP1);
  wire wr_work = wr_en && (wr_addr == PSS_A_WORK);
  wire wr_pcl = wr_en && (wr_addr == PSS_A_PCL);
  wire wr_table_address_low = wr_en && (wr_addr == PSS_A_TABLE_ADDRESS_LOW); // RULE12
  wire wr_ram = wr_en && is_ram(wr_addr); // RULE19

  // A resolved address of 00H/02H hits nothing on write
  wire wr_local = (wr_addr == PSS_A_IND0) || (wr_addr == PSS_A_IND1)
    || (wr_addr == PSS_A_MP0) || (wr_addr == PSS_A_MP1)
    || (wr_addr == PSS_A_WORK) || (wr_addr == PSS_A_PCL)
    || (wr_addr == PSS_A_TABLE_ADDRESS_LOW) || (wr_addr == PSS_A_TABLE_READ_HIGH)
    || is_ram(wr_addr); // RULE23
  wire rd_local = (rd_addr == PSS_A_IND0) || (rd_addr == PSS_A_IND1)
    || (rd_addr == PSS_A_MP0) || (rd_addr == PSS_A_MP1)
    || (rd_addr == PSS_A_WORK) || (rd_addr == PSS_A_PCL)
    || (rd_addr == PSS_A_TABLE_ADDRESS_LOW) || (rd_addr == PSS_A_TABLE_READ_HIGH)
    || is_ram(rd_addr);

  assign SFR_ADDR = tbl_wr ? wr_addr : (DM_WR ? wr_addr : rd_addr);
  assign SFR_WR = wr_en && !wr_local;
  assign SFR_WDATA = wr_data;

  // Read select
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = SFR_RDATA;
    if (is_ram(rd_addr)) begin
      rd_mux = ram_q[ram_ri];
    end else begin
      case (rd_addr)
        PSS_A_IND0: rd_mux = PSS_ZERO8; // RULE23
        PSS_A_IND1: rd_mux = PSS_ZERO8; // RULE23
        PSS_A_MP0: rd_mux = mp0_q;
        PSS_A_MP1: rd_mux = mp1_q;
        PSS_A_WORK: rd_mux = work_q;
        PSS_A_PCL: rd_mux = pc_q[7:0];
        PSS_A_TABLE_ADDRESS_LOW: rd_mux = table_address_low_q;
        PSS_A_TABLE_READ_HIGH: rd_mux = table_read_high_q;
        default: rd_mux = SFR_RDATA;
      endcase
    end
  end

  // Short jump: pending write or one landing in the last clock
  wire pcl_pend = pcl_load_q || wr_pcl;
  wire [7:0] pcl_val = wr_pcl ? wr_data : pcl_val_q;
  wire op_pcl = executing && pcl_pend;

  // Interrupts only where no extra cycle follows
  wire transfer = op_jump || op_ret || op_skip || op_pcl;
  wire boundary = end_cyc && !transfer && !op_tbl; // RULE26
  wire irq_any = IRQ_EXT_REQ || IRQ_T0_REQ || IRQ_T1_REQ;
  wire irq_take = boundary && irq_any && !sif.full; // RULE17
  wire [11:0] irq_vec = IRQ_EXT_REQ ? PSS_VEC_EXT
    : (IRQ_T0_REQ ? PSS_VEC_T0 : PSS_VEC_T1);
  wire [2:0] ack_d = !irq_take ? 3'h0
    : (IRQ_EXT_REQ ? 3'h1 : (IRQ_T0_REQ ? 3'h2 : 3'h4));

  // Return address is the prefetched word's address
  assign sif.push = end_cyc && (op_call || irq_take); // RULE15
  assign sif.push_pc = fetch_addr_q;
  assign sif.pop = end_cyc && op_ret; // RULE15

  always_comb begin
    case (state_q)
      PSS_ST_DUMMY,
      PSS_ST_RUN,
      PSS_ST_TABLE: begin
        if (transfer || irq_take) begin
          state_d = PSS_ST_DUMMY; // RULE8
        end else if (op_tbl) begin
          state_d = PSS_ST_TABLE; // RULE13
        end else begin
          state_d = PSS_ST_RUN;
        end
      end
      default: state_d = PSS_ST_DUMMY;
    endcase
  end

  assign PM_ADDR = fetching ? pc_q : tbl_addr_q; // RULE2
  assign PM_RD = (phase_q == PSS_PH_FETCH);
  assign INSTR = instr_q;
  assign INSTR_VALID = executing;
  assign CYCLE_PHASE = phase_q;
  assign PROGRAM_COUNTER = pc_q;
  assign IRQ_ACK = ack_q;
  assign DM_RDATA = rdata_q;
  assign WORKING_REGISTER = work_q;

  // Four clocks per instruction cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      phase_q <= PSS_PH_FETCH;
      state_q <= PSS_ST_DUMMY;
    end else begin
      phase_q <= phase_q + 1'b1; // RULE24
      if (end_cyc) begin
        state_q <= state_d;
      end
    end
  end

  // Program counter
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pc_q <= PSS_VEC_RESET; // RULE3
    end else if (end_cyc && op_jump) begin
      pc_q <= EXEC_TARGET; // RULE10
    end else if (end_cyc && op_ret) begin
      pc_q <= sif.top_pc; // RULE10
    end else if (end_cyc && op_pcl) begin
      pc_q <= {pc_q[11:8], pcl_val}; // RULE9
    end else if (irq_take) begin
      pc_q <= irq_vec; // RULE4 RULE5 RULE6
    end else if (capt && fetching) begin
      pc_q <= pc_q + 1'b1; // RULE1 RULE7
    end
  end

  // Fetch pipeline; a skip simply leaves the fetched word unused
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      fetch_addr_q <= PSS_VEC_RESET;
      prefetch_q <= '0;
      instr_q <= '0;
    end else begin
      if (capt && fetching) begin
        prefetch_q <= PM_DATA; // RULE24
        fetch_addr_q <= pc_q;
      end
      if (end_cyc && state_d == PSS_ST_RUN) begin
        instr_q <= prefetch_q; // RULE7
      end
    end
  end

  // Table read: address set up now, fetched next cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      tbl_addr_q <= '0;
      tbl_dest_q <= '0;
      table_read_high_q <= '0;
    end else begin
      if (end_cyc && op_tcur) begin
        tbl_addr_q <= {pc_q[11:8], table_address_low_q}; // RULE11
        tbl_dest_q <= EXEC_TARGET[7:0];
      end else if (end_cyc && op_tlast) begin
        tbl_addr_q <= {PSS_LAST_PAGE, table_address_low_q}; // RULE11
        tbl_dest_q <= EXEC_TARGET[7:0];
      end
      if (tbl_wr) begin
        table_read_high_q <= {1'b0, PM_DATA[14:8]}; // RULE11 RULE12
      end
    end
  end

  // Software registers held here
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      mp0_q <= '0;
      mp1_q <= '0;
      work_q <= '0;
      table_address_low_q <= '0;
      pcl_load_q <= 1'b0;
      pcl_val_q <= '0;
      ack_q <= '0;
      rdata_q <= '0;
    end else begin
      if (wr_mp0) mp0_q <= wr_data; // RULE25
      if (wr_mp1) mp1_q <= wr_data; // RULE25
      if (wr_work) work_q <= wr_data; // RULE20
      if (wr_table_address_low) table_address_low_q <= wr_data; // RULE12
      if (end_cyc) begin
        pcl_load_q <= 1'b0;
      end else if (wr_pcl) begin
        pcl_load_q <= 1'b1;
        pcl_val_q <= wr_data;
      end
      ack_q <= ack_d; // RULE17
      rdata_q <= rd_mux; // RULE21
    end
  end

  // General storage; bit ops are read-modify-write via the port
  always_ff @(posedge REF_CLK) begin
    if (wr_ram) begin
      ram_q[ram_wi] <= wr_data; // RULE19 RULE21
    end
  end
endmodule

/* File: tb/pss_pm_model.sv */
// Purpose: program memory model beside the sequencer
// Assumes: read word appears one clock after the read strobe
// Notes: each idle clock inverts the data, so the stale word returns every second clock
`timescale 1ns/1ps
module pss_pm_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic [11:0] addr,
  output logic [14:0] data
);
  logic [14:0] mem [4096];
  initial data = 15'h0000;
  always @(posedge clk) begin
    if (rd) begin
      data <= mem[addr];
    end else begin
      data <= ~data;
    end
  end
endmodule

/* File: tb/pss_sequencer_assertions.sv */
// Purpose: port-level checks of the program sequencer
// Assumes: table pointer is only written directly at 07H
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
module pss_sequencer_assertions
  import pss_pkg::*;
#(
  parameter int STACK_DEPTH = PSS_STACK_DEPTH
) (
  input logic REF_CLK,
  input logic RESET,
  input logic [11:0] PM_ADDR,
  input logic PM_RD,
  input logic INSTR_VALID,
  input logic [1:0] CYCLE_PHASE,
  input logic [11:0] PROGRAM_COUNTER,
  input logic [2:0] EXEC_OP,
  input logic [11:0] EXEC_TARGET,
  input logic IRQ_EXT_REQ,
  input logic IRQ_T0_REQ,
  input logic [2:0] IRQ_ACK,
  input logic [7:0] DM_ADDR,
  input logic DM_WR,
  input logic [7:0] DM_WDATA
);
  logic [7:0] table_address_low_q;
  logic [3:0] pc_hi;
  logic end_v;
  assign pc_hi = PROGRAM_COUNTER[11:8];
  assign end_v = INSTR_VALID && CYCLE_PHASE == PSS_PH_END;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      table_address_low_q <= 8'h00;
    end else if (DM_WR && DM_ADDR == PSS_A_TABLE_ADDRESS_LOW) begin
      table_address_low_q <= DM_WDATA;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  a_phase_step: assert property (
    !$past(RESET) |-> CYCLE_PHASE == 2'($past(CYCLE_PHASE) + 2'h1))
    else $error("phase did not step");
  a_fetch_phase: assert property (
    PM_RD == (CYCLE_PHASE == PSS_PH_FETCH))
    else $error("fetch strobe outside phase 0");
  a_fetch_advance: assert property (
    PM_RD && PM_ADDR == PROGRAM_COUNTER |-> ##2
    PROGRAM_COUNTER == 12'($past(PROGRAM_COUNTER, 2) + 12'h001))
    else $error("counter not advanced after fetch");
  a_reset_entry: assert property (
    $fell(RESET) |-> PROGRAM_COUNTER == PSS_VEC_RESET && !INSTR_VALID)
    else $error("counter not at 000 after reset");
  a_vector_map: assert property (
    IRQ_ACK != 3'h0 |-> PROGRAM_COUNTER == (IRQ_ACK == 3'h1 ?
    PSS_VEC_EXT : IRQ_ACK == 3'h2 ? PSS_VEC_T0 : PSS_VEC_T1))
    else $error("wrong interrupt vector");
  a_ack_priority: assert property (
    IRQ_ACK != 3'h0 |-> $past(CYCLE_PHASE) == PSS_PH_END && IRQ_ACK ==
    ($past(IRQ_EXT_REQ) ? 3'h1 : $past(IRQ_T0_REQ) ? 3'h2 : 3'h4))
    else $error("acknowledge off boundary or priority");
  a_ack_dummy: assert property (
    IRQ_ACK != 3'h0 |=> (IRQ_ACK == 3'h0 && !INSTR_VALID) [*3])
    else $error("no dummy cycle after acknowledge");
  a_branch_load: assert property (
    end_v && (EXEC_OP == PSS_OP_JUMP || EXEC_OP == PSS_OP_CALL) |=>
    (PROGRAM_COUNTER == $past(EXEC_TARGET) ##0 (!INSTR_VALID) [*4]))
    else $error("branch target or dummy cycle wrong");
  a_skip_hold: assert property (
    end_v && EXEC_OP == PSS_OP_SKIP |=>
    (PROGRAM_COUNTER == $past(PROGRAM_COUNTER) ##0 (!INSTR_VALID) [*4]))
    else $error("skip did not discard prefetched word");
  a_table_last: assert property (
    end_v && EXEC_OP == PSS_OP_TBL_LAST |=>
    (PM_ADDR == {PSS_LAST_PAGE, table_address_low_q} && !INSTR_VALID) [*4])
    else $error("last page table address wrong");
  a_pcl_jump: assert property (
    end_v && DM_WR && DM_ADDR == PSS_A_PCL && EXEC_OP == PSS_OP_NONE
    |=> PROGRAM_COUNTER == {$past(pc_hi), $past(DM_WDATA)})
    else $error("short jump left the page");
endmodule
bind pss_sequencer pss_sequencer_assertions #(
  .STACK_DEPTH(STACK_DEPTH)
) pss_sequencer_assertions_inst (.REF_CLK, .RESET, .PM_ADDR, .PM_RD,
  .INSTR_VALID, .CYCLE_PHASE, .PROGRAM_COUNTER, .EXEC_OP, .EXEC_TARGET,
  .IRQ_EXT_REQ, .IRQ_T0_REQ, .IRQ_ACK, .DM_ADDR, .DM_WR, .DM_WDATA);

/* File: tb/pss_sequencer_test.sv */
// Purpose: self-checking bench for the program sequencer
// Assumes: bench plays the datapath and interrupt sources
// Notes: each word encodes its address, so INSTR names it
`timescale 1ns/1ps
module pss_sequencer_test import pss_pkg::*;;
  logic REF_CLK, RESET, PM_RD, INSTR_VALID, DM_WR, SFR_WR;
  logic [11:0] PM_ADDR, PROGRAM_COUNTER, EXEC_TARGET;
  logic [14:0] PM_DATA, INSTR, w;
  logic [1:0] CYCLE_PHASE;
  logic [2:0] EXEC_OP, IRQ_ACK, irq_req, ack_seen;
  logic IRQ_EXT_REQ, IRQ_T0_REQ, IRQ_T1_REQ;
  logic [7:0] DM_ADDR, DM_WDATA, DM_RDATA, WORKING_REGISTER;
  logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
  logic [11:0] ret_q[$];
  logic [11:0] cur;
  int err_total = 0;
  int n_compared = 0;
  assign {IRQ_T1_REQ, IRQ_T0_REQ, IRQ_EXT_REQ} = irq_req;
  assign SFR_RDATA = SFR_ADDR ^ 8'hC3;
  pss_sequencer pss_sequencer_inst (.REF_CLK, .RESET, .PM_ADDR, .PM_RD,
    .PM_DATA, .INSTR, .INSTR_VALID, .CYCLE_PHASE, .PROGRAM_COUNTER,
    .EXEC_OP, .EXEC_TARGET, .IRQ_EXT_REQ, .IRQ_T0_REQ, .IRQ_T1_REQ,
    .IRQ_ACK, .DM_ADDR, .DM_WR, .DM_WDATA, .DM_RDATA, .WORKING_REGISTER,
    .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_RDATA);
  pss_pm_model pss_pm_model_inst (.clk(REF_CLK), .rd(PM_RD),
    .addr(PM_ADDR), .data(PM_DATA));
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  // Sampled before the design's edge updates land
  always @(posedge REF_CLK) begin
    if (IRQ_ACK !== 3'h0) ack_seen = IRQ_ACK;
  end
  function automatic logic [14:0] wd(logic [11:0] a);
    return {3'h5, a ^ 12'h5A5};
  endfunction
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_for(logic [1:0] ph);
    int k;
    k = 0;
    while (!(INSTR_VALID === 1'b1 && CYCLE_PHASE === ph) && k < 64) begin
      tick(1);
      k++;
    end
    check("wait bound", 16'(k < 64), 16'h0001);
  endtask
  task automatic expect_at(logic [11:0] a);
    wait_for(2'h0);
    check("INSTR", 16'(INSTR), 16'(wd(a)));
  endtask
  task automatic exec(pss_op_t op, logic [11:0] t);
    wait_for(PSS_PH_END);
    EXEC_OP = op;
    EXEC_TARGET = t;
    tick(1);
    EXEC_OP = PSS_OP_NONE;
  endtask
  // Extra clock keeps each write a separate strobe
  task automatic dm_wr(logic [7:0] a, logic [7:0] d);
    DM_ADDR = a;
    DM_WDATA = d;
    DM_WR = 1'b1;
    tick(1);
    DM_WR = 1'b0;
    tick(1);
  endtask
  task automatic dm_chk(logic [7:0] a, logic [7:0] e);
    DM_ADDR = a;
    tick(1);
    check("DM_RDATA", 16'(DM_RDATA), 16'(e));
  endtask
  task automatic take(logic [2:0] src, logic [11:0] vec);
    int k;
    k = 0;
    ack_seen = 3'h0;
    while (ack_seen === 3'h0 && k < 64) begin
      tick(1);
      k++;
    end
    check("IRQ_ACK", 16'(ack_seen), 16'(src));
    irq_req = irq_req & ~src;
    expect_at(vec);
    exec(PSS_OP_RET, 12'h000);
  endtask
  task automatic t_reset();
    check("PC", 16'(PROGRAM_COUNTER), 16'h0000);
    check("WORK", 16'(WORKING_REGISTER), 16'h0000);
    dm_chk(PSS_A_TABLE_ADDRESS_LOW, 8'h00);
    expect_at(12'h000);
    exec(PSS_OP_NONE, 12'h000);
    expect_at(12'h001);
  endtask
  task automatic t_branch();
    exec(PSS_OP_JUMP, 12'h345);
    expect_at(12'h345);
    exec(PSS_OP_CALL, 12'h500);
    expect_at(12'h500);
    exec(PSS_OP_RET, 12'h000);
    expect_at(12'h346);
    exec(PSS_OP_SKIP, 12'h000);
    expect_at(12'h348);
    wait_for(PSS_PH_END);
    dm_wr(PSS_A_PCL, 8'h77);
    expect_at(12'h377);
  endtask
  task automatic t_table();
    exec(PSS_OP_JUMP, 12'h9A0);
    expect_at(12'h9A0);
    dm_wr(PSS_A_TABLE_ADDRESS_LOW, 8'hC5);
    exec(PSS_OP_TBL_CUR, 12'h025);
    check("PM_ADDR", 16'(PM_ADDR), 16'h09C5);
    check("INSTR_VALID", 16'(INSTR_VALID), 16'h0000);
    expect_at(12'h9A1);
    w = wd(12'h9C5);
    dm_chk(8'h25, w[7:0]);
    dm_chk(PSS_A_TABLE_READ_HIGH, {1'b0, w[14:8]});
    dm_wr(PSS_A_TABLE_READ_HIGH, 8'hFF);
    dm_chk(PSS_A_TABLE_READ_HIGH, {1'b0, w[14:8]});
    dm_chk(PSS_A_TABLE_ADDRESS_LOW, 8'hC5);
    exec(PSS_OP_TBL_LAST, 12'h030);
    check("PM_ADDR", 16'(PM_ADDR), 16'h0FC5);
    wait_for(2'h0);
    w = wd(12'hFC5);
    dm_chk(8'h30, w[7:0]);
  endtask
  task automatic t_data();
    dm_wr(8'h40, 8'hA5);
    dm_wr(PSS_A_MP0, 8'h40);
    dm_chk(PSS_A_IND0, 8'hA5);
    dm_wr(PSS_A_MP1, 8'hFF);
    dm_wr(PSS_A_IND1, 8'h3E);
    dm_chk(8'hFF, 8'h3E);
    dm_chk(PSS_A_MP1, 8'hFF);
    dm_wr(PSS_A_MP0, PSS_A_IND1);
    dm_wr(PSS_A_IND0, 8'h77);
    dm_chk(PSS_A_IND0, 8'h00);
    dm_wr(PSS_A_WORK, 8'hE1);
    check("WORK", 16'(WORKING_REGISTER), 16'h00E1);
    dm_chk(8'h0B, 8'h0B ^ 8'hC3);
    // Special locations not held here go out on the side port
    DM_ADDR = 8'h0B;
    DM_WDATA = 8'h5A;
    DM_WR = 1'b1;
    #1;
    check("SFR_WR", 16'(SFR_WR), 16'h0001);
    check("SFR_ADDR", 16'(SFR_ADDR), 16'h000B);
    check("SFR_WDATA", 16'(SFR_WDATA), 16'h005A);
    tick(1);
    DM_WR = 1'b0;
    tick(1);
  endtask
  task automatic t_stack();
    logic [11:0] r;
    exec(PSS_OP_JUMP, 12'h600);
    cur = 12'h600;
    for (int i = 1; i <= 17; i++) begin
      ret_q.push_back(cur + 12'h001);
      if (ret_q.size() > 16) ret_q.delete(0);
      cur = 12'h600 + 12'(i * 8);
      exec(PSS_OP_CALL, cur);
    end
    expect_at(cur);
    ack_seen = 3'h0;
    irq_req = 3'h1;
    tick(24);
    check("IRQ_ACK", 16'(ack_seen), 16'h0000);
    r = ret_q.pop_back();
    exec(PSS_OP_RET, 12'h000);
    take(3'h1, PSS_VEC_EXT);
    irq_req = 3'h6;
    take(3'h2, PSS_VEC_T0);
    take(3'h4, PSS_VEC_T1);
    expect_at(r);
    while (ret_q.size() > 0) begin
      cur = ret_q.pop_back();
      exec(PSS_OP_RET, 12'h000);
      expect_at(cur);
    end
  endtask
  initial begin
    #500000;
    err_total++;
    close_out();
  end
  initial begin
    RESET = 1'b1;
    EXEC_OP = PSS_OP_NONE;
    EXEC_TARGET = 12'h000;
    irq_req = 3'h0;
    ack_seen = 3'h0;
    DM_ADDR = 8'h00;
    DM_WR = 1'b0;
    DM_WDATA = 8'h00;
    for (int a = 0; a < 4096; a++) pss_pm_model_inst.mem[a] = wd(12'(a));
    tick(20);
    RESET = 1'b0;
    t_reset();
    t_branch();
    t_table();
    t_data();
    t_stack();
    close_out();
  end
endmodule
